// *** hdpm_tick.sv ***
// Shared constants and the millisecond / 20 ms tick divider
`timescale 1ns/10ps
`default_nettype none

package hdpm_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned UNIT_MS = 20;
  localparam logic [7:0] ADDR_DISABLE = 8'hff;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [8:0] STEP_ONE = 9'h001;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PRE = 3'h1,
    ST_RTSW = 3'h3,
    ST_SEND = 3'h2,
    ST_RTSOFF = 3'h6,
    ST_WACK = 3'h7,
    ST_RWAIT = 3'h5
  } hdpm_state_t;
endpackage

module hdpm_tick #(
  parameter int unsigned CYC_PER_MS = hdpm_pkg::CYC_PER_MS
) (
  input wire logic mclk_in,      // System clock
  input wire logic rst_n_in,     // Synchronous reset, active low
  output logic tick_ms_out,      // One-cycle pulse every 1 ms
  output logic tick_20ms_out     // One-cycle pulse every 20 ms
);
  typedef struct packed {
    logic [15:0] div;
    logic [4:0] ms;
    logic t1;
    logic t20;
  } hdpm_tick_t;

  localparam logic [15:0] DIV_LAST = 16'(CYC_PER_MS - 1);
  localparam logic [4:0] MS_LAST = 5'(hdpm_pkg::UNIT_MS - 1);

  hdpm_tick_t q;
  hdpm_tick_t d;

  always_comb begin
    d = q;
    d.t1 = 1'b0;
    d.t20 = 1'b0;
    if (q.div == DIV_LAST) begin
      d.div = '0;
      d.t1 = 1'b1;
      if (q.ms == MS_LAST) begin
        d.ms = '0;
        d.t20 = 1'b1;
      end else begin
        d.ms = q.ms + 5'h01;
      end
    end else begin
      d.div = q.div + 16'h0001;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_ms_out = q.t1;
  assign tick_20ms_out = q.t20;
endmodule

`default_nettype wire

// *** hdpm_core.sv ***
// Half-duplex poll master: link timing, retries and poll scheduling
`timescale 1ns/10ps
`default_nettype none

module hdpm_core #(
  parameter int unsigned CYC_PER_MS = hdpm_pkg::CYC_PER_MS
) (
  input wire logic mclk_in,                     // System clock, 50 MHz
  input wire logic rst_n_in,                    // Synchronous reset, low
  input wire logic handshake_in,                // 1: RTS/CTS modem mode
  input wire logic msg_poll_mode_in,            // 1: message-based polling
  input wire logic [15:0] rts_send_delay_in,    // RTS to CTS, 20 ms units
  input wire logic [15:0] rts_off_delay_in,     // RTS hold, 20 ms units
  input wire logic [15:0] pre_tx_delay_in,      // Pre-transmit, 1 ms units
  input wire logic [7:0] retries_in,            // Message retry count
  input wire logic [7:0] ack_timeout_in,        // Ack timeout, 20 ms units
  input wire logic [7:0] reply_timeout_in,      // Reply wait, 20 ms units
  input wire logic [7:0] pri_lo_in,             // Priority range first
  input wire logic [7:0] pri_hi_in,             // Priority range last
  input wire logic [7:0] nrm_lo_in,             // Normal range first
  input wire logic [7:0] nrm_hi_in,             // Normal range last
  input wire logic [7:0] group_size_in,         // Normal poll group size
  input wire logic ladder_message_request_in,   // Message request, level
  input wire logic [7:0] msg_dest_in,           // Message destination
  input wire logic cts_in,                      // Clear to send
  input wire logic tx_done_in,                  // Last char sent, pulse
  input wire logic rx_done_in,                  // Last char received, pulse
  input wire logic ack_in,                      // Acknowledge seen, pulse
  input wire logic poll_resp_in,                // Poll answered, pulse
  output logic rts_out,                         // Request to send
  output logic tx_start_out,                    // Start a packet, pulse
  output logic tx_is_poll_out,                  // 1: packet is a poll
  output logic [7:0] tx_addr_out,               // Packet station address
  output logic msg_busy_out,                    // Message in progress
  output logic msg_done_out,                    // Message acknowledged
  output logic msg_fail_out,                    // Message failed, pulse
  output logic poll_timeout_out,                // Poll unanswered, pulse
  output logic [254:0] active_out               // Active station table
);
  typedef struct packed {
    hdpm_pkg::hdpm_state_t st;
    logic rts;
    logic [15:0] tmr;
    logic [15:0] gap;
    logic job_msg;
    logic [7:0] tries;
    logic [7:0] addr;
    logic phase;
    logic [7:0] pptr;
    logic [7:0] nptr;
    logic [7:0] grp;
    logic [8:0] steps;
    logic [255:0] active;
    logic busy;
    logic done;
    logic fail;
    logic tx_start;
    logic poll_to;
  } hdpm_regs_t;

  hdpm_regs_t q;
  hdpm_regs_t d;
  logic tick_ms;
  logic tick_20ms;
  logic unit_tick;
  logic pre_ok;
  logic nrm_end;

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == hdpm_pkg::CNT_MAX) ? v : v + 16'h0001;
  endfunction

  function automatic logic [7:0] inc8(input logic [7:0] v);
    inc8 = v + hdpm_pkg::BYTE_ONE;
  endfunction

  hdpm_tick #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_tick (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .tick_ms_out(tick_ms),
    .tick_20ms_out(tick_20ms)
  );

  // Only the pre-transmit wait counts whole milliseconds
  assign unit_tick = (q.st == hdpm_pkg::ST_PRE) ? tick_ms : tick_20ms;
  // In modem mode the gap since the last received character is what counts
  assign pre_ok = handshake_in ? (q.gap >= pre_tx_delay_in)
                               : (q.tmr >= pre_tx_delay_in);
  // Group size 0 means no limit; the step count still ends the pass
  assign nrm_end = (nrm_lo_in == hdpm_pkg::ADDR_DISABLE) ||
                   ((group_size_in != '0) && (q.grp >= group_size_in)) ||
                   (q.steps > {1'b0, nrm_hi_in - nrm_lo_in});

  always_comb begin
    d = q;
    d.tx_start = 1'b0;
    d.done = 1'b0;
    d.fail = 1'b0;
    d.poll_to = 1'b0;
    if (tick_ms) begin
      d.gap = sat_inc(q.gap);
    end
    if (rx_done_in) begin
      d.gap = '0;
    end
    if (unit_tick) begin
      d.tmr = sat_inc(q.tmr);
    end
    unique case (q.st)
      hdpm_pkg::ST_IDLE: begin
        d.tmr = '0;
        if (ladder_message_request_in) begin
          d.job_msg = 1'b1;
          d.addr = msg_dest_in;
          d.tries = '0;
          d.busy = 1'b1;
          d.st = hdpm_pkg::ST_PRE;
        end else if (!msg_poll_mode_in) begin
          d.job_msg = 1'b0;
          if (!q.phase) begin
            if (pri_lo_in == hdpm_pkg::ADDR_DISABLE ||
                q.pptr > pri_hi_in) begin
              d.phase = 1'b1;
              d.grp = '0;
              d.steps = '0;
              d.pptr = pri_lo_in;
            end else if (q.pptr < pri_lo_in) begin
              d.pptr = pri_lo_in;
            end else begin
              d.addr = q.pptr;
              d.pptr = inc8(q.pptr);
              d.st = hdpm_pkg::ST_PRE;
            end
          end else if (nrm_end) begin
            d.phase = 1'b0;
            d.pptr = pri_lo_in;
          end else if (q.nptr < nrm_lo_in || q.nptr > nrm_hi_in) begin
            d.nptr = nrm_lo_in;
          end else begin
            d.addr = q.nptr;
            d.nptr = (q.nptr >= nrm_hi_in) ? nrm_lo_in : inc8(q.nptr);
            d.steps = q.steps + hdpm_pkg::STEP_ONE;
            if (q.active[q.nptr]) begin
              d.grp = inc8(q.grp);
            end
            d.st = hdpm_pkg::ST_PRE;
          end
        end
      end
      hdpm_pkg::ST_PRE: begin
        if (pre_ok) begin
          d.tmr = '0;
          if (handshake_in) begin
            d.rts = 1'b1;
            d.st = hdpm_pkg::ST_RTSW;
          end else begin
            d.tx_start = 1'b1;
            d.st = hdpm_pkg::ST_SEND;
          end
        end
      end
      hdpm_pkg::ST_RTSW: begin
        // CTS is looked at only once the send delay has run out
        if (q.tmr >= rts_send_delay_in && cts_in) begin
          d.tmr = '0;
          d.tx_start = 1'b1;
          d.st = hdpm_pkg::ST_SEND;
        end
      end
      hdpm_pkg::ST_SEND: begin
        if (tx_done_in) begin
          d.tmr = '0;
          d.st = handshake_in ? hdpm_pkg::ST_RTSOFF : hdpm_pkg::ST_WACK;
        end
      end
      hdpm_pkg::ST_RTSOFF: begin
        if (q.tmr >= rts_off_delay_in) begin
          d.rts = 1'b0;
          d.tmr = '0;
          d.st = hdpm_pkg::ST_WACK;
        end
      end
      hdpm_pkg::ST_WACK: begin
        if (q.job_msg) begin
          if (ack_in) begin
            d.done = 1'b1;
            d.busy = 1'b0;
            d.tmr = '0;
            d.st = msg_poll_mode_in ? hdpm_pkg::ST_RWAIT
                                    : hdpm_pkg::ST_IDLE;
          end else if (q.tmr >= {8'h00, ack_timeout_in}) begin
            d.tmr = '0;
            if (q.tries < retries_in) begin
              d.tries = inc8(q.tries);
              d.st = hdpm_pkg::ST_PRE;
            end else begin
              d.fail = 1'b1;
              d.busy = 1'b0;
              d.st = hdpm_pkg::ST_IDLE;
            end
          end
        end else if (poll_resp_in) begin
          d.active[q.addr] = (q.addr != hdpm_pkg::ADDR_DISABLE);
          d.st = hdpm_pkg::ST_IDLE;
        end else if (q.tmr >= {8'h00, ack_timeout_in}) begin
          d.active[q.addr] = 1'b0;
          d.poll_to = 1'b1;
          d.st = hdpm_pkg::ST_IDLE;
        end
      end
      hdpm_pkg::ST_RWAIT: begin
        if (q.tmr >= {8'h00, reply_timeout_in}) begin
          d.job_msg = 1'b0;
          d.tmr = '0;
          d.st = hdpm_pkg::ST_PRE;
        end
      end
      default: begin
        d.st = hdpm_pkg::ST_IDLE;
        d.rts = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      q <= '0;
      q.gap <= hdpm_pkg::CNT_MAX;
    end else begin
      q <= d;
    end
  end

  assign rts_out = q.rts;
  assign tx_start_out = q.tx_start;
  assign tx_is_poll_out = ~q.job_msg;
  assign tx_addr_out = q.addr;
  assign msg_busy_out = q.busy;
  assign msg_done_out = q.done;
  assign msg_fail_out = q.fail;
  assign poll_timeout_out = q.poll_to;
  assign active_out = q.active[254:0];
endmodule

`default_nettype wire

// *** hdpm_checker.sv ***
// Port assertions for the half-duplex poll master core
`timescale 1ns/10ps
`default_nettype none
module hdpm_checker (
  input wire logic mclk_in,                    // System clock
  input wire logic rst_n_in,                   // Reset, active low
  input wire logic handshake_in,               // Modem mode
  input wire logic msg_poll_mode_in,           // Message-based polling
  input wire logic [7:0] pri_lo_in,            // Priority range first
  input wire logic [7:0] nrm_lo_in,            // Normal range first
  input wire logic cts_in,                     // Clear to send
  input wire logic ack_in,                     // Acknowledge pulse
  input wire logic rts_out,                    // Request to send
  input wire logic tx_start_out,               // Packet start pulse
  input wire logic tx_is_poll_out,             // Packet is a poll
  input wire logic msg_busy_out,               // Message in progress
  input wire logic msg_done_out,               // Message acknowledged
  input wire logic msg_fail_out                // Message failed
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  property p_start_pulse;
    tx_start_out |=> !tx_start_out;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("tx start wider than one cycle");
  property p_hs_rts;
    handshake_in && tx_start_out |-> rts_out;
  endproperty
  a_hs_rts: assert property (p_hs_rts)
    else $error("modem send without rts");
  property p_hs_cts;
    handshake_in && tx_start_out |-> $past(cts_in);
  endproperty
  a_hs_cts: assert property (p_hs_cts)
    else $error("modem send without cts");
  property p_rts_first;
    $rose(rts_out) |-> !tx_start_out [*2];
  endproperty
  a_rts_first: assert property (p_rts_first)
    else $error("send too soon after rts");
  property p_no_rts;
    !handshake_in && !$past(handshake_in) |-> !rts_out;
  endproperty
  a_no_rts: assert property (p_no_rts)
    else $error("rts raised without handshaking");
  property p_done;
    msg_done_out |-> $past(ack_in) && $past(msg_busy_out) && !msg_busy_out;
  endproperty
  a_done: assert property (p_done)
    else $error("message done without ack");
  property p_fail;
    msg_fail_out |-> $past(msg_busy_out) && !msg_busy_out;
  endproperty
  a_fail: assert property (p_fail)
    else $error("failure did not free the master");
  property p_skip;
    pri_lo_in == hdpm_pkg::ADDR_DISABLE && nrm_lo_in == hdpm_pkg::ADDR_DISABLE
    && $past(pri_lo_in, 4) == hdpm_pkg::ADDR_DISABLE
    && $past(nrm_lo_in, 4) == hdpm_pkg::ADDR_DISABLE
    && !msg_poll_mode_in && !$past(msg_poll_mode_in, 4)
    |-> !(tx_start_out && tx_is_poll_out);
  endproperty
  a_skip: assert property (p_skip)
    else $error("poll sent with both ranges off");
endmodule
`default_nettype wire

// *** hdpm_partner.sv ***
// Far-side model: modem and slave stations on the shared link
`timescale 1ns/10ps
`default_nettype none
module hdpm_partner (
  input wire logic clk_in,           // Clock
  input wire logic rts_in,           // Request to send
  input wire logic tx_start_in,      // Packet start
  input wire logic is_poll_in,       // Packet is a poll
  input wire logic [7:0] addr_in,    // Station address
  input wire logic [254:0] live_in,  // Stations that answer polls
  input wire logic ack_en_in,        // Acknowledge messages
  output logic cts_out,              // Clear to send
  output logic tx_done_out,          // Last char sent
  output logic rx_done_out,          // Last char received
  output logic ack_out,              // Acknowledge seen
  output logic resp_out              // Poll answered
);
  int cnt = -1;
  logic [2:0] rts_q = 3'h0;
  logic poll_q = 1'b0;
  logic ans_q = 1'b0;
  // Modem turn-on lag, so CTS is never there the moment RTS rises
  assign cts_out = rts_q[2];
  always @(posedge clk_in) begin
    rts_q <= {rts_q[1:0], rts_in};
    {tx_done_out, rx_done_out, ack_out, resp_out} <= 4'h0;
    if (tx_start_in) begin
      cnt <= 0;
      poll_q <= is_poll_in;
      ans_q <= is_poll_in ? live_in[addr_in] : ack_en_in;
    end else if (cnt >= 0) begin
      cnt <= cnt + 1;
      if (cnt == 4) tx_done_out <= 1'b1;
      // A modem slave cannot answer until the master lets the line go
      if (cnt >= 12 && !rts_in) begin
        cnt <= -1;
        rx_done_out <= ans_q;
        ack_out <= ans_q && !poll_q;
        resp_out <= ans_q && poll_q;
      end
    end
  end
endmodule
`default_nettype wire

// *** hdpm_core_tb_top.sv ***
// Self-checking testbench for the poll master core
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin \
  miscompares++; $display("Error %s exp %0h got %0h", n, e, s); end end
module hdpm_core_tb_top;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic hs = 1'b0, mpm = 1'b0, req = 1'b0, ack_en = 1'b1;
  logic [15:0] sdly = 16'h0000, odly = 16'h0000, pre = 16'h0000;
  logic [7:0] rty = 8'h03, ato = 8'h02, dest = 8'h00;
  logic [7:0] plo = 8'hff, phi = 8'hff, nlo = 8'hff;
  logic [7:0] nhi = 8'h00, grp = 8'h00;
  logic [254:0] live = '0;
  logic [7:0] q[$];
  wire logic cts, txd, rxd, ack, rsp, rts, txs, isp, busy, done, fail, pto;
  wire logic [7:0] addr;
  wire logic [254:0] act;
  int miscompares = 0, checks = 0, starts, tos, t_up, t_tx, t_txd, t_dn;
  hdpm_core #(.CYC_PER_MS(4)) i_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .handshake_in(hs),
    .msg_poll_mode_in(mpm), .rts_send_delay_in(sdly),
    .rts_off_delay_in(odly), .pre_tx_delay_in(pre), .retries_in(rty),
    .ack_timeout_in(ato), .reply_timeout_in(8'h01), .pri_lo_in(plo),
    .pri_hi_in(phi), .nrm_lo_in(nlo), .nrm_hi_in(nhi),
    .group_size_in(grp), .ladder_message_request_in(req),
    .msg_dest_in(dest), .cts_in(cts), .tx_done_in(txd), .rx_done_in(rxd),
    .ack_in(ack), .poll_resp_in(rsp), .rts_out(rts), .tx_start_out(txs),
    .tx_is_poll_out(isp), .tx_addr_out(addr), .msg_busy_out(busy),
    .msg_done_out(done), .msg_fail_out(fail), .poll_timeout_out(pto),
    .active_out(act));
  hdpm_partner i_far (.clk_in(mclk_in), .rts_in(rts), .tx_start_in(txs),
    .is_poll_in(isp), .addr_in(addr), .live_in(live), .ack_en_in(ack_en),
    .cts_out(cts), .tx_done_out(txd), .rx_done_out(rxd), .ack_out(ack),
    .resp_out(rsp));
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Runs until a message ends or lim cycles pass, logging link events
  task automatic run(input logic r, input int lim);
    int n;
    n = 0; starts = 0; tos = 0; t_up = -1; t_tx = -1; t_txd = -1; t_dn = -1;
    q.delete();
    @(posedge mclk_in);
    req <= r;
    while (n < lim && done !== 1'b1 && fail !== 1'b1) begin
      @(posedge mclk_in);
      n++;
      if (busy === 1'b1) req <= 1'b0;
      if (rts === 1'b1 && t_up < 0) t_up = n;
      if (rts !== 1'b1 && t_up >= 0 && t_dn < 0) t_dn = n;
      if (txd === 1'b1) t_txd = n;
      if (pto === 1'b1) tos++;
      if (txs === 1'b1) begin
        starts++;
        q.push_back(addr);
        if (t_tx < 0) t_tx = n;
      end
    end
  endtask
  task automatic t_msg;
    pre <= 16'h0002;
    dest <= 8'h0a;
    run(1'b1, 2000);
    `CHK("msg_done", 1'b1, done)
    `CHK("tries", 1, starts)
    `CHK("pre_gap", 1'b1, t_tx >= 4 && t_tx <= 14)
    $display("t_msg over");
  endtask
  task automatic t_retry;
    pre <= 16'h0000;
    ack_en <= 1'b0;
    rty <= 8'h02;
    run(1'b1, 3000);
    `CHK("msg_fail", 1'b1, fail)
    `CHK("tries", 3, starts)
    ack_en <= 1'b1;
    $display("t_retry over");
  endtask
  task automatic t_modem;
    int a, b;
    hs <= 1'b1;
    sdly <= 16'h0002;
    odly <= 16'h0002;
    run(1'b1, 3000);
    a = t_tx - t_up;
    b = t_dn - t_txd;
    `CHK("msg_done", 1'b1, done)
    `CHK("rts_to_send", 1'b1, a >= 80 && a <= 200)
    `CHK("rts_hold", 1'b1, b >= 80 && b <= 200)
    hs <= 1'b0;
    $display("t_modem over");
  endtask
  task automatic t_poll;
    plo <= 8'h05;
    phi <= 8'h06;
    live[5] <= 1'b1;
    run(1'b0, 400);
    plo <= 8'hff;
    `CHK("poll_first", 8'h05, q[0])
    `CHK("poll_second", 8'h06, q[1])
    `CHK("active_5", 1'b1, act[5])
    `CHK("active_6", 1'b0, act[6])
    `CHK("poll_timeouts", 1'b1, tos > 0)
    repeat (200) @(posedge mclk_in);
    run(1'b0, 300);
    `CHK("polls_off", 0, starts)
    $display("t_poll over");
  endtask
  task automatic t_reply;
    mpm <= 1'b1;
    dest <= 8'h0c;
    live[12] <= 1'b1;
    run(1'b1, 2000);
    `CHK("msg_done", 1'b1, done)
    run(1'b0, 400);
    `CHK("reply_poll", 8'h0c, q[0])
    $display("t_reply over");
  endtask
  // Scan start phase is left over from earlier tests, so skip a few polls
  task automatic t_group;
    int bad;
    bad = 0;
    mpm <= 1'b0;
    plo <= 8'h05;
    phi <= 8'h05;
    live[8] <= 1'b1;
    live[9] <= 1'b1;
    nlo <= 8'h08;
    nhi <= 8'h09;
    grp <= 8'h01;
    run(1'b0, 1000);
    for (int k = 4; k + 1 < q.size(); k++) begin
      if ((q[k] == 8'h05) == (q[k + 1] == 8'h05)) bad++;
    end
    `CHK("group_polls", 1'b1, q.size() >= 10)
    `CHK("group_alt", 0, bad)
    nlo <= 8'hff;
    grp <= 8'h00;
    $display("t_group over");
  endtask
  initial begin
    forever #10 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    `CHK("poll_flag", 1'b1, isp)
    `CHK("rts", 1'b0, rts)
    t_msg();
    t_retry();
    t_modem();
    t_poll();
    t_reply();
    t_group();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    miscompares++;
    end_of_test();
  end
endmodule
bind hdpm_core hdpm_checker i_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .handshake_in(handshake_in), .msg_poll_mode_in(msg_poll_mode_in),
  .pri_lo_in(pri_lo_in), .nrm_lo_in(nrm_lo_in), .cts_in(cts_in),
  .ack_in(ack_in), .rts_out(rts_out), .tx_start_out(tx_start_out),
  .tx_is_poll_out(tx_is_poll_out), .msg_busy_out(msg_busy_out),
  .msg_done_out(msg_done_out), .msg_fail_out(msg_fail_out));
`default_nettype wire
